// [bdc_checker.sv]
// Checker for bdc_top, bound to every instance.
// Assumes the analog inputs are synchronous to mclk.
`timescale 1ns/1ps
module bdc_checker (
    // Watched ports
    input wire logic mclk,
    input wire logic reset,
    input wire logic on_bit,
    input wire logic voltage_scaling,
    input wire logic fault_interrupt_enable,
    input wire logic status_read,
    input wire logic below_good_threshold,
    input wire logic converter_enable,
    input wire logic [bdc_pkg::CODE_W-1:0] applied_setting,
    input wire logic discharge_en,
    input wire logic output_good_flag,
    input wire logic oc_shutdown,
    input wire logic interrupt_request_low_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_DISCHARGE: assert property (discharge_en == !converter_enable)
        else $error("discharge not inverse of enable");
    AST_OFF: assert property (!on_bit |=> !converter_enable)
        else $error("converter stayed on");
    AST_GOOD: assert property (!$past(reset) |-> output_good_flag == !$past(below_good_threshold))
        else $error("good flag wrong");
    AST_IRQ: assert property (fault_interrupt_enable && below_good_threshold && converter_enable
        |=> interrupt_request_low_oe) else $error("interrupt not raised");
    AST_HOLD: assert property (interrupt_request_low_oe && !status_read |=> interrupt_request_low_oe)
        else $error("interrupt dropped without read");
    AST_READ: assert property (interrupt_request_low_oe && status_read && below_good_threshold
        && converter_enable |=> interrupt_request_low_oe) else $error("read in fault cleared");
    AST_STEP: assert property (voltage_scaling && $past(voltage_scaling) && $changed(applied_setting)
        |-> (applied_setting - $past(applied_setting)) inside {6'h01, 6'h3f}) else $error("step too big");
    AST_SHUT: assert property (oc_shutdown |=> !converter_enable)
        else $error("shutdown ignored");
    cover property (oc_shutdown);
    cover property (interrupt_request_low_oe && status_read);
    cover property (voltage_scaling && $changed(applied_setting));
endmodule : bdc_checker
bind bdc_top bdc_checker chk (.*);

// [bdc_host_model.sv]
// Host model: turns each toggle of rd_req into one status_read pulse.
// Assumes the bench toggles rd_req no more than once every two cycles.
`timescale 1ns/1ps
module bdc_host_model (
    // Clock and request
    input wire logic mclk,
    input wire logic rd_req,
    // Read strobe
    output logic status_read
);
    logic req_q = 1'b0;
    logic rd_q = 1'b0;
    assign status_read = rd_q;
    always @(posedge mclk)
    begin
        req_q <= rd_req;
        rd_q <= rd_req ^ req_q;
    end
endmodule : bdc_host_model

// [bdc_pkg.sv]
// Constants and types for the buck regulator digital control block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Notes on behaviour
// - Regulate to primary setting normally, primary or scaled while scaling is active.
// - With scaling enabled, step applied code one code at a time to target.
// - Enable the 40 ohm pull-down during downward scaling steps.
// - Suppress overvoltage and undervoltage faults while stepping between settings.
// - Rewriting the setting in use gives no fault suppression.
// - Host on bit turns the converter on or off.
// - Discharge resistor connected while converter is disabled, removed when enabled.
// - Output good flag is 0 below power-good threshold, else 1.
// - Enabled fault interrupt and low output drive the interrupt line active; the code does so only while the converter is enabled (run_q).
// - Interrupt held until converter off or regulating and status read.
// - Only a read made after the fault is gone clears the interrupt.
// - Peak current at limit turns the power switch off for that cycle.
// - Undervoltage from shortened cycles shuts the converter down.
// - Two consecutive cycles at 125 percent raise warning and interrupt.
// - Eight consecutive cycles at 125 percent shut the converter down.
// - Setting is a 6-bit code, 0.6 V plus 50 mV per step.
package bdc_pkg;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned VOUT_BASE_MV = 600;
    localparam int unsigned VOUT_STEP_MV = 50;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned STEP_TIME_US = 10;
    localparam int unsigned STEP_CYCLES = (CLK_HZ / 1000000) * STEP_TIME_US;
    localparam int unsigned OC_WARN_COUNT = 2;
    localparam int unsigned OC_SHUT_COUNT = 8;
    localparam int unsigned OC_CNT_W = 4;
    localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;
    typedef enum logic [2:0]
    {
        BDC_IDLE = 3'b001,
        BDC_RAMP = 3'b010,
        BDC_WAIT = 3'b100
    } bdc_ramp_state_t;
endpackage : bdc_pkg

// [bdc_step_if.sv]
// Interface carrying the stepper request and applied code.
// Assumes the stepper and the top share mclk.
`timescale 1ns/1ps
interface bdc_step_if;
    import bdc_pkg::*;
    logic [CODE_W-1:0] target;
    logic [CODE_W-1:0] applied;
    logic ramping;
    logic going_down;
    modport ctrl (output target, input applied, input ramping, input going_down);
    modport stepper (input target, output applied, output ramping, output going_down);
endinterface : bdc_step_if

// [bdc_stepper.sv]
// Steps the applied setting code toward a target one code per interval.
// Assumes the target is stable or changes only by host writes.
`timescale 1ns/1ps
module bdc_stepper #(
    parameter int unsigned STEP_INTERVAL = bdc_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Mode
    input wire logic scale_en,
    // Carrier
    bdc_step_if.stepper sif
);
    import bdc_pkg::*;
    localparam int unsigned TW = $clog2(STEP_INTERVAL + 1);
    localparam logic [TW-1:0] TLOAD = TW'(STEP_INTERVAL - 1);
    bdc_ramp_state_t st_q, st_d;
    logic [CODE_W-1:0] app_q, app_d;
    logic [TW-1:0] tmr_q, tmr_d;

    always_comb
    begin
        st_d = st_q;
        app_d = app_q;
        tmr_d = tmr_q;
        case (st_q)
            BDC_IDLE:
            begin
                if (sif.target != app_q)
                begin
                    if (scale_en)
                    begin
                        st_d = BDC_WAIT;
                        tmr_d = TLOAD;
                    end
                    else
                    begin
                        // A direct jump is never masked, so software must keep it small.
                        app_d = sif.target;
                    end
                end
            end
            BDC_WAIT:
            begin
                // The ramp state costs a cycle of its own, so the wait ends one count early.
                if (tmr_q > TW'(1))
                    tmr_d = tmr_q - 1'b1;
                else
                    st_d = BDC_RAMP;
            end
            BDC_RAMP:
            begin
                if (sif.target > app_q)
                    app_d = app_q + 1'b1;
                else if (sif.target < app_q)
                    app_d = app_q - 1'b1;
                if (app_d == sif.target)
                    st_d = BDC_IDLE;
                else
                begin
                    st_d = BDC_WAIT;
                    tmr_d = TLOAD;
                end
            end
            default:
            begin
                st_d = BDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_q <= BDC_IDLE;
            app_q <= CODE_RESET;
            tmr_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            app_q <= app_d;
            tmr_q <= tmr_d;
        end
    end

    assign sif.applied = app_q;
    assign sif.ramping = (st_q != BDC_IDLE) && (sif.target != app_q);
    assign sif.going_down = sif.ramping && (sif.target < app_q);
endmodule : bdc_stepper

// [bdc_top.sv]
// Digital control of one step-down converter: scaling, enable, power good, interrupt, overcurrent.
// Assumes analog comparators deliver synchronous levels and a per-cycle strobe.
`timescale 1ns/1ps
module bdc_top #(
    parameter int unsigned STEP_INTERVAL = bdc_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Host control bits
    input wire logic on_bit,
    input wire logic voltage_scaling,
    input wire logic scale_select,
    input wire logic [bdc_pkg::CODE_W-1:0] primary_voltage_setting,
    input wire logic [bdc_pkg::CODE_W-1:0] scaled_voltage_setting,
    input wire logic fault_interrupt_enable,
    input wire logic status_read,
    input wire logic [2:0] peak_current_limit_setting,
    // Analog comparator inputs
    input wire logic below_good_threshold,
    input wire logic ov_detect,
    input wire logic uv_detect,
    input wire logic cycle_start,
    input wire logic peak_at_limit,
    input wire logic peak_over_125,
    // Analog controls
    output logic converter_enable,
    output logic [bdc_pkg::CODE_W-1:0] applied_setting,
    output logic [2:0] current_limit_code,
    output logic switch_off,
    output logic slew_pulldown_en,
    output logic discharge_en,
    // Status
    output logic output_good_flag,
    output logic overvoltage_fault,
    output logic undervoltage_fault,
    output logic oc_warning,
    output logic oc_shutdown,
    output logic interrupt_request_low,
    output logic interrupt_request_low_oe
);
    import bdc_pkg::*;
    bdc_step_if sif ();
    logic run_q, run_d;
    logic pg_pend_q, pg_pend_d;
    logic oc_pend_q, oc_pend_d;
    logic [OC_CNT_W-1:0] occ_q, occ_d;
    logic ov_q, ov_d, uv_q, uv_d;
    logic good_q, good_d;
    logic swoff_q, swoff_d;
    logic ocw_q, ocw_d, ocs_q, ocs_d;
    logic uvs_q, uvs_d;

    // The scaled code is only chosen while scaling is active.
    assign sif.target = (voltage_scaling && scale_select) ? scaled_voltage_setting : primary_voltage_setting;

    bdc_stepper #(.STEP_INTERVAL(STEP_INTERVAL)) u_step (
        .mclk(mclk),
        .reset(reset),
        .scale_en(voltage_scaling),
        .sif(sif)
    );

    always_comb
    begin
        run_d = on_bit && !ocs_q && !uvs_q;
        good_d = !below_good_threshold;
        ov_d = ov_q;
        uv_d = uv_q;
        if (!sif.ramping && run_q)
        begin
            ov_d = ov_q | ov_detect;
            uv_d = uv_q | uv_detect;
        end
        if (status_read)
        begin
            if (!ov_detect)
                ov_d = 1'b0;
            if (!uv_detect)
                uv_d = 1'b0;
        end
        // Undervoltage shutdown holds until the host cycles the on bit.
        uvs_d = on_bit && (uvs_q || (run_q && !sif.ramping && uv_detect));
        swoff_d = swoff_q;
        if (cycle_start)
            swoff_d = 1'b0;
        if (peak_at_limit)
            swoff_d = 1'b1;
        occ_d = occ_q;
        if (cycle_start)
        begin
            if (!peak_over_125)
                occ_d = '0;
            else if (occ_q != OC_CNT_W'(OC_SHUT_COUNT))
                occ_d = occ_q + 1'b1;
        end
        // A stale count would shut the converter down again as soon as it is re-enabled.
        if (!run_q)
            occ_d = '0;
        ocw_d = ocw_q || (occ_q >= OC_CNT_W'(OC_WARN_COUNT));
        ocs_d = on_bit && (ocs_q || (occ_q >= OC_CNT_W'(OC_SHUT_COUNT)));
        if (status_read && occ_q < OC_CNT_W'(OC_WARN_COUNT))
            ocw_d = 1'b0;
        oc_pend_d = oc_pend_q;
        if (status_read)
            oc_pend_d = 1'b0;
        if (occ_q >= OC_CNT_W'(OC_WARN_COUNT))
            oc_pend_d = 1'b1;
        pg_pend_d = pg_pend_q;
        // A read clears only once the converter is off or back in regulation.
        if (status_read && (!run_q || !below_good_threshold))
            pg_pend_d = 1'b0;
        if (fault_interrupt_enable && run_q && below_good_threshold)
            pg_pend_d = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            run_q <= 1'b0;
            good_q <= 1'b0;
            ov_q <= 1'b0;
            uv_q <= 1'b0;
            uvs_q <= 1'b0;
            swoff_q <= 1'b0;
            occ_q <= '0;
            ocw_q <= 1'b0;
            ocs_q <= 1'b0;
            oc_pend_q <= 1'b0;
            pg_pend_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            good_q <= good_d;
            ov_q <= ov_d;
            uv_q <= uv_d;
            uvs_q <= uvs_d;
            swoff_q <= swoff_d;
            occ_q <= occ_d;
            ocw_q <= ocw_d;
            ocs_q <= ocs_d;
            oc_pend_q <= oc_pend_d;
            pg_pend_q <= pg_pend_d;
        end
    end

    assign converter_enable = run_q;
    assign discharge_en = !run_q;
    assign applied_setting = sif.applied;
    assign current_limit_code = peak_current_limit_setting;
    assign switch_off = swoff_q || !run_q;
    assign slew_pulldown_en = run_q && sif.going_down;
    assign output_good_flag = good_q;
    assign overvoltage_fault = ov_q;
    assign undervoltage_fault = uv_q;
    assign oc_warning = ocw_q;
    assign oc_shutdown = ocs_q;
    // Open drain: the pin is only ever driven low.
    assign interrupt_request_low = 1'b0;
    assign interrupt_request_low_oe = pg_pend_q || oc_pend_q;
endmodule : bdc_top

// [tb.sv]
// Self-checking bench for bdc_top with a host model.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module tb;
    import bdc_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, on_bit = 1'b0, voltage_scaling = 1'b0, scale_select = 1'b0;
    logic fault_interrupt_enable = 1'b0, status_read, rd_req = 1'b0, below_good_threshold = 1'b0;
    logic ov_detect = 1'b0, uv_detect = 1'b0, cycle_start = 1'b0, peak_at_limit = 1'b0, peak_over_125 = 1'b0;
    logic [CODE_W-1:0] primary_voltage_setting = 6'h00, scaled_voltage_setting = 6'h00, applied_setting, p, s;
    logic [2:0] peak_current_limit_setting = 3'h0, current_limit_code;
    logic converter_enable, switch_off, slew_pulldown_en, discharge_en, output_good_flag, overvoltage_fault;
    logic undervoltage_fault, oc_warning, oc_shutdown, interrupt_request_low, interrupt_request_low_oe;
    int num_errors = 0, comparisons = 0;
    always #20 mclk = ~mclk;
    bdc_top #(.STEP_INTERVAL(3)) dut (.*);
    bdc_host_model host (.mclk(mclk), .rd_req(rd_req), .status_read(status_read));
    function automatic logic [CODE_W-1:0] one_short(input logic [CODE_W-1:0] from, input logic [CODE_W-1:0] to);
        return (to > from) ? to - 6'h01 : to + 6'h01;
    endfunction : one_short
    task automatic check(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic look(input int n);
        tick(n);
        @(negedge mclk);
    endtask : look
    task automatic rd;
        tick(1);
        rd_req <= ~rd_req;
        look(3);
    endtask : rd
    // Faults raised mid-ramp must be ignored; dropped one code early to avoid the final edge.
    task automatic ramp(input logic sel, input logic [CODE_W-1:0] t);
        logic pd;
        logic [CODE_W-1:0] near;
        pd = 1'b0;
        near = one_short(applied_setting, t);
        tick(1);
        scale_select <= sel;
        tick(1);
        ov_detect <= 1'b1;
        for (int i = 0; i < 400 && applied_setting !== near; i++)
        begin
            @(negedge mclk);
            pd = pd | slew_pulldown_en;
        end
        tick(1);
        ov_detect <= 1'b0;
        look(12);
        check("applied", 1'b1, applied_setting === t);
        check("ov masked", 1'b0, overvoltage_fault);
        check("pulldown", !sel, pd);
        $display("ramp done");
    endtask : ramp
    task automatic oc(input int n, input logic over);
        repeat (n)
        begin
            tick(1);
            peak_over_125 <= over;
            peak_at_limit <= over;
            cycle_start <= 1'b1;
            tick(1);
            cycle_start <= 1'b0;
        end
    endtask : oc
    task automatic complete_run;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial
    begin
        tick(3000);
        num_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(76319));
        p = 6'($urandom_range(20));
        s = p + 6'($urandom_range(15, 5));
        tick(4);
        reset <= 1'b0;
        on_bit <= 1'b1;
        primary_voltage_setting <= p;
        scaled_voltage_setting <= s;
        peak_current_limit_setting <= 3'($urandom);
        look(3);
        check("enable", 1'b1, converter_enable);
        check("discharge", 1'b0, discharge_en);
        check("limit", 1'b1, current_limit_code === peak_current_limit_setting);
        check("primary", 1'b1, applied_setting === p);
        check("switch on", 1'b0, switch_off);
        tick(1);
        voltage_scaling <= 1'b1;
        ramp(1'b1, s);
        ramp(1'b0, p);
        tick(1);
        voltage_scaling <= 1'b0;
        primary_voltage_setting <= p + 6'h01;
        ov_detect <= 1'b1;
        look(3);
        check("ov kept", 1'b1, overvoltage_fault);
        tick(1);
        ov_detect <= 1'b0;
        rd();
        tick(1);
        fault_interrupt_enable <= 1'b1;
        below_good_threshold <= 1'b1;
        look(2);
        check("good low", 1'b0, output_good_flag);
        check("irq set", 1'b1, interrupt_request_low_oe);
        rd();
        check("irq kept", 1'b1, interrupt_request_low_oe);
        tick(1);
        below_good_threshold <= 1'b0;
        look(3);
        check("good high", 1'b1, output_good_flag);
        check("irq wait", 1'b1, interrupt_request_low_oe);
        rd();
        check("irq clear", 1'b0, interrupt_request_low_oe);
        check("pin", 1'b0, interrupt_request_low);
        $display("power good done");
        oc(1, 1'b1);
        oc(1, 1'b0);
        oc(1, 1'b1);
        look(1);
        check("warn restart", 1'b0, oc_warning);
        check("switch off", 1'b1, switch_off);
        oc(1, 1'b1);
        look(1);
        check("warn", 1'b1, oc_warning);
        check("warn irq", 1'b1, interrupt_request_low_oe);
        oc(6, 1'b1);
        look(2);
        check("shutdown", 1'b1, oc_shutdown);
        check("off", 1'b0, converter_enable);
        tick(1);
        on_bit <= 1'b0;
        peak_over_125 <= 1'b0;
        peak_at_limit <= 1'b0;
        look(2);
        check("discharge on", 1'b1, discharge_en);
        tick(1);
        on_bit <= 1'b1;
        look(2);
        check("enable again", 1'b1, converter_enable);
        tick(1);
        uv_detect <= 1'b1;
        look(3);
        check("uv off", 1'b0, converter_enable);
        check("uv flag", 1'b1, undervoltage_fault);
        $display("protection done");
        complete_run();
    end
endmodule : tb
